// ===== rtl/half_bridge_fault_protection.sv
// fault supervisor: gate latch-off, sticky flags, operating modes
`default_nettype none
module half_bridge_fault_protection #(
   parameter int NHB = hb_fault_pkg::NUM_HB
) (
   // clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   // analog comparator pins (asynchronous)
   input  wire logic [NHB-1:0]               vds_overload,
   input  wire logic                         pump_supply_low,
   input  wire logic                         pump_below_low,
   input  wire logic                         pump_below_fail,
   input  wire logic                         vs_over_shutdown,
   input  wire logic                         vs_over_pump_limit,
   input  wire logic                         vs_under,
   input  wire logic                         logic_supply_por,
   // external pins (asynchronous)
   input  wire logic                         wake_reset_input,
   input  wire logic                         external_fail_input,
   // spi side (same clock)
   input  wire logic                         spi_frame_done,
   input  wire logic                         spi_protocol_error,
   input  wire logic                         toggle_watchdog_bit,
   input  wire logic                         read_vds_status,
   input  wire logic                         read_device_status,
   input  wire logic                         enable_write,
   input  wire logic [NHB-1:0]               half_bridge_enable_bits,
   input  wire logic                         global_restart,
   input  wire logic [NHB-1:0]               high_side_cmd,
   input  wire logic [NHB-1:0]               low_side_cmd,
   input  wire logic [NHB-1:0]               test_current_req,
   // gate and pump outputs
   output logic [NHB-1:0]                    high_side_gate_out,
   output logic [NHB-1:0]                    low_side_gate_out,
   output logic                              charge_pump_enable,
   output logic                              switched_pump_output,
   output logic                              pump_discharge,
   output logic                              hs_pulldown_reduced,
   output logic [NHB-1:0]                    test_current_en,
   // status outputs
   output logic [NHB-1:0]                    vds_fault_status_reg,
   output logic [hb_fault_pkg::DS_W-1:0]     device_status_reg,
   output logic                              mode_normal,
   output logic                              mode_failsafe
);
   localparam int NF = NHB + 6;
   localparam int NP = NF + 3;

   initial begin
      if (NHB != hb_fault_pkg::NUM_HB) $error("NHB must match the package bridge count");
   end

   typedef struct packed {
      logic [NP-1:0]                 sync1;      // first synchroniser stage
      logic [NP-1:0]                 sync2;      // second stage
      hb_fault_pkg::mode_t           mode;       // operating mode
      logic                          wake_prev;  // for wake rising edge
      logic                          wd_prev;    // last watchdog bit seen
      logic [NHB-1:0]                hb_on;      // bridge enabled and not tripped
      logic                          hs_trip;    // high sides latched off
      logic                          all_trip;   // all gates latched off
      logic [NHB-1:0]                vds_flag;
      logic [hb_fault_pkg::DS_W-1:0] dev;
      logic [NHB-1:0]                hs_q;
      logic [NHB-1:0]                ls_q;
      logic                          pump_q;
      logic                          switched_pump_output_q;
      logic                          disch_q;
      logic                          pd_red_q;
      logic [NHB-1:0]                tst_q;
      logic                          mn_q;       // registered normal decode
      logic                          mf_q;       // registered failsafe decode
   } state_t;
   state_t st;
   state_t next_st;

   logic [NP-1:0] pins;   // raw pins into the synchroniser
   logic [NF-1:0] filt;   // de-glitched levels

   assign pins = {logic_supply_por, vs_over_shutdown, vs_over_pump_limit,
                  external_fail_input, wake_reset_input, vs_under, vs_over_shutdown,
                  pump_below_fail, pump_supply_low | pump_below_low, vds_overload};

   // one filter per synchronised condition except the three extra pins (limit, shutdown, reset)
   genvar gi;
   generate
      for (gi = 0; gi < NF; gi++) begin : g_filt
         dgl_filter #(
            .CYCLES (hb_fault_pkg::filt_cyc(gi))
         ) u_filt (
            .clk_sys   (clk_sys),
            .rst       (rst),
            .level_in  (st.sync2[gi]),
            .level_out (filt[gi])
         );
      end
   endgenerate

   // next-state logic
   always_comb begin
      logic ov_now;     // synced level above shutdown threshold
      logic lim_now;    // synced level above pump limit
      logic wd_good;    // frame carried a toggled watchdog bit
      logic spi_err;
      logic enter_nm;
      logic [hb_fault_pkg::DS_W-1:0] dev_set;
      ov_now   = st.sync2[hb_fault_pkg::P_OVSD];
      lim_now  = st.sync2[hb_fault_pkg::P_LIMIT];
      wd_good  = spi_frame_done && (toggle_watchdog_bit != st.wd_prev);
      spi_err  = spi_protocol_error || (spi_frame_done && !wd_good);
      enter_nm = 1'b0;
      dev_set  = '0;
      next_st  = st;
      next_st.sync1     = pins;
      next_st.sync2     = st.sync1;
      next_st.wake_prev = filt[hb_fault_pkg::F_WAKE];
      if (spi_frame_done) next_st.wd_prev = toggle_watchdog_bit;

      // mode transitions
      unique case (st.mode)
         hb_fault_pkg::MODE_SLEEP: begin
            if (filt[hb_fault_pkg::F_WAKE] && !st.wake_prev) enter_nm = 1'b1;
         end
         hb_fault_pkg::MODE_NORMAL: begin
            if (!filt[hb_fault_pkg::F_WAKE]) next_st.mode = hb_fault_pkg::MODE_SLEEP;
            else if (spi_err || filt[hb_fault_pkg::F_FAIL])
               next_st.mode = hb_fault_pkg::MODE_FAILSAFE;
         end
         hb_fault_pkg::MODE_FAILSAFE: begin
            if (!filt[hb_fault_pkg::F_WAKE]) next_st.mode = hb_fault_pkg::MODE_SLEEP;
            else if (wd_good && !filt[hb_fault_pkg::F_FAIL]) enter_nm = 1'b1;
         end
      endcase

      // flag clear on read; flags survive the move into failsafe
      if (read_vds_status) next_st.vds_flag = '0;
      if (read_device_status) next_st.dev = st.dev & ~hb_fault_pkg::DS_CLR_ON_READ;

      // comm flag follows frame quality
      if (spi_err) next_st.dev[hb_fault_pkg::DS_NM] = 1'b0;
      else if (spi_frame_done) next_st.dev[hb_fault_pkg::DS_NM] = 1'b1;

      if (st.mode == hb_fault_pkg::MODE_NORMAL) begin
         // enable writes only take a bridge whose flag is clear
         if (enable_write) next_st.hb_on = half_bridge_enable_bits & ~st.vds_flag;
         // local overload: set wins over read clear
         for (int i = 0; i < NHB; i++) begin
            if (filt[i] && next_st.hb_on[i]) begin
               next_st.vds_flag[i] = 1'b1;
               next_st.hb_on[i]    = 1'b0;
            end
         end
         // global restart only once the matching flags are read
         if (global_restart) begin
            if (!st.dev[hb_fault_pkg::DS_OVF]) next_st.hs_trip = 1'b0;
            if (!st.dev[hb_fault_pkg::DS_CPF] && !st.dev[hb_fault_pkg::DS_UVF])
               next_st.all_trip = 1'b0;
         end
         dev_set[hb_fault_pkg::DS_CPL] = filt[hb_fault_pkg::F_CPL];
         dev_set[hb_fault_pkg::DS_CPF] = filt[hb_fault_pkg::F_CPF] && !ov_now;
         dev_set[hb_fault_pkg::DS_OVF] = filt[hb_fault_pkg::F_OV];
         dev_set[hb_fault_pkg::DS_UVF] = filt[hb_fault_pkg::F_UV];
         if (dev_set[hb_fault_pkg::DS_CPF] || dev_set[hb_fault_pkg::DS_UVF])
            next_st.all_trip = 1'b1;
         if (dev_set[hb_fault_pkg::DS_OVF]) next_st.hs_trip = 1'b1;
         next_st.dev = next_st.dev | dev_set;
      end

      // normal entry clears everything except a fresh reset flag
      if (enter_nm) begin
         next_st.mode     = hb_fault_pkg::MODE_NORMAL;
         next_st.hb_on    = '0;
         next_st.hs_trip  = 1'b0;
         next_st.all_trip = 1'b0;
         next_st.vds_flag = '0;
         next_st.dev      = '0;
         next_st.dev[hb_fault_pkg::DS_RCF] = 1'b1;
      end
      // logic supply reset wins over everything, no filter
      if (st.sync2[hb_fault_pkg::P_POR]) begin
         next_st.mode  = hb_fault_pkg::MODE_SLEEP;
         next_st.hb_on = '0;
      end

      // gates: full operation in the nominal band, off outside normal
      if (next_st.mode == hb_fault_pkg::MODE_NORMAL && !next_st.all_trip) begin
         next_st.hs_q = high_side_cmd & next_st.hb_on
                        & {NHB{!next_st.hs_trip && !ov_now}};
         next_st.ls_q = low_side_cmd & next_st.hb_on;
      end else begin
         next_st.hs_q = '0;
         next_st.ls_q = '0;
      end
      // pump runs through under-voltage, stops above its limit
      next_st.pump_q   = (next_st.mode == hb_fault_pkg::MODE_NORMAL) && !lim_now;
      next_st.switched_pump_output_q   = next_st.pump_q;
      next_st.disch_q  = next_st.pump_q ? 1'b0 : lim_now;
      next_st.pd_red_q = ov_now;
      next_st.tst_q    = (next_st.mode == hb_fault_pkg::MODE_NORMAL && !ov_now
                          && !next_st.all_trip && !next_st.hs_trip)
                         ? test_current_req : '0;
      // mode decodes registered so the outputs come straight from flops
      next_st.mn_q     = (next_st.mode == hb_fault_pkg::MODE_NORMAL);
      next_st.mf_q     = (next_st.mode == hb_fault_pkg::MODE_FAILSAFE);
   end

   // state register; reset leaves the device asleep
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) st <= '0;
      else st <= next_st;
   end

   // outputs straight from flops
   assign high_side_gate_out   = st.hs_q;
   assign low_side_gate_out    = st.ls_q;
   assign charge_pump_enable   = st.pump_q;
   assign switched_pump_output = st.switched_pump_output_q;
   assign pump_discharge       = st.disch_q;
   assign hs_pulldown_reduced  = st.pd_red_q;
   assign test_current_en      = st.tst_q;
   assign vds_fault_status_reg = st.vds_flag;
   assign device_status_reg    = st.dev;
   assign mode_normal          = st.mn_q;
   assign mode_failsafe        = st.mf_q;

   // checks on the design's own outputs
   a_vds_gate_off: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(st.vds_flag[0]) |-> !st.hs_q[0] && !st.ls_q[0])
      else $error("bridge 0 driven while overload flag rises");
   a_flag_blocks_on: assert property (@(posedge clk_sys) disable iff (rst)
      st.vds_flag[0] |-> !st.hs_q[0] && !st.ls_q[0])
      else $error("flagged bridge 0 switched on");
   a_flag_sticky: assert property (@(posedge clk_sys) disable iff (rst)
      (st.vds_flag[0] && !read_vds_status && st.mode == hb_fault_pkg::MODE_NORMAL)
      ##1 (st.mode != hb_fault_pkg::MODE_SLEEP) |-> st.vds_flag[0])
      else $error("overload flag lost without a read");
   a_cpf_all_off: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(st.dev[hb_fault_pkg::DS_CPF]) |-> (st.hs_q == '0) && (st.ls_q == '0))
      else $error("gates on after pump fail");
   a_ov_hs_off: assert property (@(posedge clk_sys) disable iff (rst)
      st.hs_trip |-> st.hs_q == '0)
      else $error("high side on during over-voltage trip");
   a_spi_err_fs: assert property (@(posedge clk_sys) disable iff (rst)
      (spi_protocol_error && st.mode == hb_fault_pkg::MODE_NORMAL
       && !st.sync2[hb_fault_pkg::P_POR] && filt[hb_fault_pkg::F_WAKE])
      |=> st.mode == hb_fault_pkg::MODE_FAILSAFE ##1 (st.hs_q == '0 && !st.pump_q))
      else $error("spi error did not reach failsafe");
   a_por_sleep: assert property (@(posedge clk_sys) disable iff (rst)
      st.sync2[hb_fault_pkg::P_POR] |=> st.mode == hb_fault_pkg::MODE_SLEEP)
      else $error("power-on reset did not force sleep");
   a_rcf_entry: assert property (@(posedge clk_sys) disable iff (rst)
      (st.mode == hb_fault_pkg::MODE_NORMAL && $past(st.mode) != hb_fault_pkg::MODE_NORMAL)
      |-> st.dev[hb_fault_pkg::DS_RCF] && st.vds_flag == '0)
      else $error("normal entry without reset flag");
   a_pump_limit: assert property (@(posedge clk_sys) disable iff (rst)
      st.sync2[hb_fault_pkg::P_LIMIT] |=> !st.pump_q && st.disch_q)
      else $error("pump left on above its limit");
   c_vds_trip: cover property (@(posedge clk_sys) disable iff (rst) $rose(st.vds_flag[0]));
   c_fs_entry: cover property (@(posedge clk_sys) disable iff (rst)
      $rose(st.mode == hb_fault_pkg::MODE_FAILSAFE));
   c_fs_exit: cover property (@(posedge clk_sys) disable iff (rst)
      $past(st.mode) == hb_fault_pkg::MODE_FAILSAFE && st.mode == hb_fault_pkg::MODE_NORMAL);
   c_ov_trip: cover property (@(posedge clk_sys) disable iff (rst) $rose(st.hs_trip));
endmodule : half_bridge_fault_protection
`default_nettype wire

// ===== rtl/hb_fault_pkg.sv
// constants, types and timing for the half-bridge fault supervisor
`default_nettype none
package hb_fault_pkg;
   localparam int NUM_HB    = 6;       // half-bridges
   localparam int CLK_MHZ   = 200;     // clk_sys rate
   // de-glitch times in ns, plain defaults
   localparam int T_VDS_DGL_NS = 1000;
   localparam int T_CPL_DGL_NS = 2000;
   localparam int T_CPF_DGL_NS = 2000;
   localparam int T_OV_DGL_NS  = 2000;
   localparam int T_UV_DGL_NS  = 2000;
   localparam int T_IN_DGL_NS  = 200;  // logic input filter
   // least times round up to whole cycles
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cyc
   // filtered condition indices, vds first
   localparam int F_CPL  = NUM_HB;
   localparam int F_CPF  = NUM_HB + 1;
   localparam int F_OV   = NUM_HB + 2;
   localparam int F_UV   = NUM_HB + 3;
   localparam int F_WAKE = NUM_HB + 4;
   localparam int F_FAIL = NUM_HB + 5;
   localparam int NUM_F  = NUM_HB + 6;
   // per-filter cycle count
   function automatic int filt_cyc(input int idx);
      if (idx < NUM_HB) return ns_to_cyc(T_VDS_DGL_NS);
      if (idx == F_CPL) return ns_to_cyc(T_CPL_DGL_NS);
      if (idx == F_CPF) return ns_to_cyc(T_CPF_DGL_NS);
      if (idx == F_OV) return ns_to_cyc(T_OV_DGL_NS);
      if (idx == F_UV) return ns_to_cyc(T_UV_DGL_NS);
      return ns_to_cyc(T_IN_DGL_NS);
   endfunction : filt_cyc
   // device status bit positions
   localparam int DS_W   = 8;
   localparam int DS_RCF = 0;
   localparam int DS_CPL = 1;
   localparam int DS_CPF = 2;
   localparam int DS_OVF = 3;
   localparam int DS_UVF = 4;
   localparam int DS_NM  = 5;
   localparam logic [DS_W-1:0] DS_CLR_ON_READ = 8'h1F;
   // raw synchroniser vector: extra pins after the filtered ones
   localparam int P_LIMIT = NUM_F;
   localparam int P_OVSD  = NUM_F + 1;
   localparam int P_POR   = NUM_F + 2;
   localparam int NUM_P   = NUM_F + 3;
   typedef enum logic [1:0] {MODE_SLEEP, MODE_NORMAL, MODE_FAILSAFE} mode_t;
endpackage : hb_fault_pkg
`default_nettype wire

// ===== rtl/dgl_filter.sv
// digital de-glitch filter: output follows input only after a steady run
`default_nettype none
module dgl_filter #(
   parameter int CYCLES = 1
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // levels
   input  wire logic level_in,
   output logic      level_out
);
   localparam int CW = (CYCLES < 2) ? 1 : $clog2(CYCLES + 1);
   typedef struct packed {
      logic [CW-1:0] cnt;    // steady-run count
      logic          q;      // filtered level
   } filt_t;
   filt_t st;
   filt_t next_st;

   initial begin
      if (CYCLES < 1) $error("dgl_filter: CYCLES must be at least 1");
   end

   // count while input differs from output; any return restarts
   always_comb begin
      next_st = st;
      if (level_in == st.q) begin
         next_st.cnt = '0;
      end else if (st.cnt == CW'(CYCLES - 1)) begin
         next_st.q   = level_in;
         next_st.cnt = '0;
      end else begin
         next_st.cnt = st.cnt + CW'(1);
      end
   end

   // state register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) st <= '0;
      else st <= next_st;
   end

   assign level_out = st.q;
endmodule : dgl_filter
`default_nettype wire

// ===== tb/mcu_model.sv
// supervising controller model: spi frame strobes with watchdog bit
`default_nettype none
module mcu_model (
   // clock
   input  wire logic clk_sys,
   // frame requests from the bench
   input  wire logic send_req,
   input  wire logic keep_bit,
   // frame strobes to the device
   output logic      spi_frame_done,
   output logic      toggle_watchdog_bit
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle lines before the first frame
   initial begin
      spi_frame_done = 1'b0;
      toggle_watchdog_bit = 1'b0;
   end
   // one-cycle frame strobe; the bit flips unless a stale frame is asked for
   always @(posedge clk_sys) begin
      spi_frame_done <= send_req;
      if (send_req && !keep_bit) begin
         toggle_watchdog_bit <= ~toggle_watchdog_bit;
      end
   end
endmodule : mcu_model
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the half-bridge fault supervisor
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   // clock, reset and pins
   logic       clk_sys, rst, send_req, keep_bit;
   logic [5:0] vds_overload, half_bridge_enable_bits, high_side_cmd, low_side_cmd;
   logic [5:0] test_current_req;
   logic       pump_supply_low, pump_below_low, pump_below_fail, vs_over_shutdown;
   logic       vs_over_pump_limit, vs_under, logic_supply_por, wake_reset_input;
   logic       external_fail_input, spi_protocol_error, read_vds_status;
   logic       read_device_status, enable_write, global_restart;
   wire logic  spi_frame_done, toggle_watchdog_bit;
   // device outputs
   logic [5:0] high_side_gate_out, low_side_gate_out, test_current_en, vds_fault_status_reg;
   logic [7:0] device_status_reg;
   logic       charge_pump_enable, switched_pump_output, pump_discharge;
   logic       hs_pulldown_reduced, mode_normal, mode_failsafe;
   // bookkeeping
   int         n_mismatch = 0;
   int         cmp_count  = 0;
   int         cycles     = 0;
   half_bridge_fault_protection half_bridge_fault_protection_inst (.clk_sys(clk_sys),
      .rst(rst), .vds_overload(vds_overload), .pump_supply_low(pump_supply_low),
      .pump_below_low(pump_below_low), .pump_below_fail(pump_below_fail),
      .vs_over_shutdown(vs_over_shutdown), .vs_over_pump_limit(vs_over_pump_limit),
      .vs_under(vs_under), .logic_supply_por(logic_supply_por),
      .wake_reset_input(wake_reset_input), .external_fail_input(external_fail_input),
      .spi_frame_done(spi_frame_done), .spi_protocol_error(spi_protocol_error),
      .toggle_watchdog_bit(toggle_watchdog_bit), .read_vds_status(read_vds_status),
      .read_device_status(read_device_status), .enable_write(enable_write),
      .half_bridge_enable_bits(half_bridge_enable_bits), .global_restart(global_restart),
      .high_side_cmd(high_side_cmd), .low_side_cmd(low_side_cmd),
      .test_current_req(test_current_req), .high_side_gate_out(high_side_gate_out),
      .low_side_gate_out(low_side_gate_out), .charge_pump_enable(charge_pump_enable),
      .switched_pump_output(switched_pump_output), .pump_discharge(pump_discharge),
      .hs_pulldown_reduced(hs_pulldown_reduced), .test_current_en(test_current_en),
      .vds_fault_status_reg(vds_fault_status_reg), .device_status_reg(device_status_reg),
      .mode_normal(mode_normal), .mode_failsafe(mode_failsafe));
   mcu_model mcu_model_inst (.clk_sys(clk_sys), .send_req(send_req), .keep_bit(keep_bit),
      .spi_frame_done(spi_frame_done), .toggle_watchdog_bit(toggle_watchdog_bit));
   // 200 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // hang guard, well above the few thousand cycles the run needs
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run
   // compare, zero-extended to a byte
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   // strobes, one cycle each, launched on a rising edge
   task automatic rd_vds;
      @(posedge clk_sys) read_vds_status <= 1'b1;
      @(posedge clk_sys) read_vds_status <= 1'b0;
   endtask : rd_vds
   task automatic rd_ds;
      @(posedge clk_sys) read_device_status <= 1'b1;
      @(posedge clk_sys) read_device_status <= 1'b0;
   endtask : rd_ds
   task automatic en(input logic [5:0] b);
      @(posedge clk_sys) enable_write <= 1'b1;
      half_bridge_enable_bits <= b;
      @(posedge clk_sys) enable_write <= 1'b0;
   endtask : en
   task automatic restart;
      @(posedge clk_sys) global_restart <= 1'b1;
      @(posedge clk_sys) global_restart <= 1'b0;
   endtask : restart
   task automatic frame(input logic k);
      @(posedge clk_sys) send_req <= 1'b1;
      keep_bit <= k;
      @(posedge clk_sys) send_req <= 0;
   endtask : frame
   // bounded waits; the filters are at most 400 cycles plus sync
   task automatic wait_ds(input int b);
      for (int i = 0; i < 600 && device_status_reg[b] !== 1'b1; i++) @(negedge clk_sys);
   endtask : wait_ds
   task automatic gates(input logic [5:0] h, input logic [5:0] l);
      @(negedge clk_sys);
      chk("high_side_gate_out", h, high_side_gate_out);
      chk("low_side_gate_out", l, low_side_gate_out);
   endtask : gates
   // wake from sleep, reset flag set then read away
   task automatic t_wake;
      @(posedge clk_sys) wake_reset_input <= 1'b1;
      for (int i = 0; i < 100 && mode_normal !== 1'b1; i++) @(negedge clk_sys);
      chk("rcf", 1, device_status_reg[hb_fault_pkg::DS_RCF]);
      rd_ds();
      @(negedge clk_sys) chk("ds", 0, device_status_reg & hb_fault_pkg::DS_CLR_ON_READ);
   endtask : t_wake
   // glitch ignored, overload trip, refused and failed restarts, good restart
   task automatic t_vds;
      en(6'h3F);
      gates(6'h15, 6'h03);
      chk("test_current_en", 6'h01, test_current_en);
      @(posedge clk_sys) vds_overload <= 6'h02;
      cyc(100);
      vds_overload <= 6'h01;
      for (int i = 0; i < 300 && vds_fault_status_reg[0] !== 1'b1; i++) @(negedge clk_sys);
      chk("vds_flags", 6'h01, vds_fault_status_reg);
      gates(6'h14, 6'h02);
      en(6'h3F);
      gates(6'h14, 6'h02);
      rd_vds();
      en(6'h3F);
      cyc(5);
      gates(6'h14, 6'h02);
      chk("vds_flags", 6'h01, vds_fault_status_reg);
      chk("test_current_en", 6'h01, test_current_en);
      @(posedge clk_sys) vds_overload <= 6'h00;
      cyc(210);
      rd_vds();
      en(6'h3F);
      cyc(2);
      gates(6'h15, 6'h03);
      chk("vds_flags", 0, vds_fault_status_reg);
   endtask : t_vds
   // over-voltage: immediate effects, latched flag, masked pump fail
   task automatic t_ov;
      @(posedge clk_sys) vs_over_shutdown <= 1'b1;
      pump_below_fail <= 1'b1;
      cyc(5);
      gates(6'h00, 6'h03);
      chk("hs_pulldown_reduced", 1, hs_pulldown_reduced);
      chk("test_current_en", 0, test_current_en);
      wait_ds(hb_fault_pkg::DS_OVF);
      chk("ovf", 1, device_status_reg[hb_fault_pkg::DS_OVF]);
      cyc(60);
      @(negedge clk_sys) chk("cpf", 0, device_status_reg[hb_fault_pkg::DS_CPF]);
      @(posedge clk_sys) pump_below_fail <= 1'b0;
      cyc(410);
      vs_over_shutdown <= 1'b0;
      cyc(5);
      @(negedge clk_sys) chk("hs_pulldown_reduced", 0, hs_pulldown_reduced);
      gates(6'h00, 6'h03);
      cyc(410);
      rd_ds();
      restart();
      cyc(2);
      gates(6'h15, 6'h03);
   endtask : t_ov
   // under-voltage and pump fail: all gates latched, pump kept
   task automatic t_glob(input int w);
      @(posedge clk_sys) if (w == 0) vs_under <= 1'b1;
      else pump_below_fail <= 1'b1;
      wait_ds(w == 0 ? hb_fault_pkg::DS_UVF : hb_fault_pkg::DS_CPF);
      gates(6'h00, 6'h00);
      chk("flag", 1, device_status_reg[w == 0 ? 4 : 2]);
      chk("charge_pump_enable", 1, charge_pump_enable);
      chk("switched_pump_output", 1, switched_pump_output);
      @(posedge clk_sys) vs_under <= 1'b0;
      pump_below_fail <= 1'b0;
      cyc(410);
      restart();
      gates(6'h00, 6'h00);
      rd_ds();
      restart();
      cyc(2);
      gates(6'h15, 6'h03);
   endtask : t_glob
   // pump low flags without shutdown; pump limit stops and discharges pump
   task automatic t_pump;
      @(posedge clk_sys) pump_below_low <= 1'b1;
      wait_ds(hb_fault_pkg::DS_CPL);
      chk("cpl", 1, device_status_reg[hb_fault_pkg::DS_CPL]);
      gates(6'h15, 6'h03);
      @(posedge clk_sys) high_side_cmd <= 6'h05;
      cyc(2);
      gates(6'h05, 6'h03);
      @(posedge clk_sys) high_side_cmd <= 6'h15;
      @(posedge clk_sys) pump_below_low <= 1'b0;
      vs_over_pump_limit <= 1'b1;
      cyc(5);
      @(negedge clk_sys) chk("charge_pump_enable", 0, charge_pump_enable);
      chk("pump_discharge", 1, pump_discharge);
      @(posedge clk_sys) vs_over_pump_limit <= 1'b0;
      cyc(410);
      rd_ds();
      @(negedge clk_sys) chk("ds", 0, device_status_reg & hb_fault_pkg::DS_CLR_ON_READ);
      chk("pump_discharge", 0, pump_discharge);
   endtask : t_pump
   // stale watchdog bit to failsafe, flags kept, toggle back to normal
   task automatic t_wd;
      frame(1'b0);
      cyc(2);
      @(negedge clk_sys) chk("nm", 1, device_status_reg[hb_fault_pkg::DS_NM]);
      @(posedge clk_sys) pump_supply_low <= 1'b1;
      wait_ds(hb_fault_pkg::DS_CPL);
      @(posedge clk_sys) pump_supply_low <= 1'b0;
      frame(1'b1);
      cyc(2);
      @(negedge clk_sys) chk("mode_failsafe", 1, mode_failsafe);
      chk("nm", 0, device_status_reg[hb_fault_pkg::DS_NM]);
      chk("cpl", 1, device_status_reg[hb_fault_pkg::DS_CPL]);
      gates(6'h00, 6'h00);
      cyc(410);
      frame(1'b0);
      cyc(2);
      @(negedge clk_sys) chk("mode_normal", 1, mode_normal);
      chk("ds", 8'h01, device_status_reg & hb_fault_pkg::DS_CLR_ON_READ);
      gates(6'h00, 6'h00);
      @(posedge clk_sys) spi_protocol_error <= 1'b1;
      @(posedge clk_sys) spi_protocol_error <= 1'b0;
      @(negedge clk_sys) chk("mode_failsafe", 1, mode_failsafe);
      frame(1'b0);
      cyc(2);
      @(negedge clk_sys) chk("mode_normal", 1, mode_normal);
   endtask : t_wd
   // logic supply reset drops to sleep at once
   task automatic t_por;
      @(posedge clk_sys) logic_supply_por <= 1'b1;
      cyc(4);
      @(negedge clk_sys) chk("modes", 0, {mode_normal, mode_failsafe});
      @(posedge clk_sys) logic_supply_por <= 1'b0;
   endtask : t_por
   // main sequence
   initial begin
      rst = 1'b1;
      {send_req, keep_bit, pump_supply_low, pump_below_low, pump_below_fail} = '0;
      {vs_over_shutdown, vs_over_pump_limit, vs_under, logic_supply_por} = '0;
      {wake_reset_input, external_fail_input, spi_protocol_error} = '0;
      {read_vds_status, read_device_status, enable_write, global_restart} = '0;
      vds_overload = 6'h00;
      half_bridge_enable_bits = 6'h00;
      high_side_cmd = 6'h15;
      low_side_cmd = 6'h03;
      test_current_req = 6'h01;
      cyc(8);
      rst <= 1'b0;
      t_wake();
      t_vds();
      t_ov();
      t_glob(0);
      t_glob(1);
      t_pump();
      t_wd();
      t_por();
      complete_run();
   end
endmodule : testbench
`default_nettype wire
